// File: pkg/sad_pkg.sv
// constants, field layouts and carrier types for the speech activity front end
package sad_pkg;

  // vector sizes
  localparam int ORDER = 8;
  localparam int NTAPS = ORDER + 1;
  localparam logic [3:0] LAST_TAP = 4'(ORDER);
  localparam int FRAMES = 4;

  // fixed-point widths and scalings
  localparam int ACF_W = 32;
  localparam int AV_W = 34;
  localparam int RV_W = 16;
  localparam int RVAD_FRAC = 10;
  localparam int COEF_W = 24;
  localparam int COEF_FRAC = 15;
  localparam int COEF_ONE = 1 << COEF_FRAC;
  localparam logic signed [COEF_W-1:0] COEF_M1 = 24'hff8000;
  localparam int R_W = 32;
  localparam int RAV_W = 24;
  localparam int ACC_W = 64;
  localparam int DIV_W = 64;
  localparam int PV_W = 40;
  localparam int TH_W = 48;
  localparam int DM_W = 40;

  // frame timing at the 200 MHz system clock
  localparam int CLK_KHZ = 200000;
  localparam int FRAME_MS = 20;
  localparam int FRAME_CYC = FRAME_MS * CLK_KHZ;

  // spectral steadiness limit 0.05 in the Q10 scale of the distortion
  localparam int STAT_THRESH_Q10 = 51;

  // threshold adaptation
  localparam int PTH = 300000;
  localparam int PLEV = 800000;
  localparam int FAC = 3;
  localparam int ADP = 8;
  localparam int INC_SH = 4;
  localparam int DEC_SH = 5;
  localparam int MARGIN = 80000000;
  localparam int TH_INIT = 1000000;

  // hangover
  localparam int BURST_CONST = 3;
  localparam int HANG_CONST = 5;

  // adaptive filter start values 6, -4, 1, 0.. in Q10
  localparam logic [NTAPS-1:0][RV_W-1:0] RVAD_INIT = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0400, 16'hf000, 16'h1800};

  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_THRESH = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_ENERGY = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_DIST = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CTRL_W = 2;
  localparam int CTRL_ADAPT_BIT = 0;
  localparam int CTRL_HANG_BIT = 1;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h3;
  localparam int ST_SPEECH_BIT = 0;
  localparam int ST_RAW_BIT = 1;
  localparam int ST_STEADY_BIT = 2;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_OVERDUE_BIT = 4;
  localparam int ST_OVR_LSB = 8;
  localparam int OVR_W = 8;

  // per-frame input from the encoder
  typedef struct packed {
    logic [NTAPS-1:0][ACF_W-1:0] acf;
    logic pitch;
    logic tone;
  } frame_in_t;

  // per-frame decision
  typedef struct packed {
    logic speech;
    logic raw_speech;
    logic steady;
  } result_t;

endpackage : sad_pkg

// File: hw/sad_divider.sv
// bit-serial unsigned divider shared by the predictor solver and distortion
`timescale 1ns/100ps
module sad_divider (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic [sad_pkg::DIV_W-1:0] dividend_i,
  input wire logic [sad_pkg::DIV_W-1:0] divisor_i,
  output logic done_o,
  output logic [sad_pkg::DIV_W-1:0] quotient_o
);
  import sad_pkg::*;

  logic [DIV_W-1:0] rem_r;
  logic [DIV_W-1:0] quo_r;
  logic [DIV_W-1:0] den_r;
  logic [6:0] cnt_r;
  logic busy_r;
  logic done_r;
  logic [DIV_W:0] shifted_w;
  logic [DIV_W:0] trial_w;
  logic fits_w;

  // one quotient bit per cycle, restoring form
  assign shifted_w = {rem_r, quo_r[DIV_W-1]};
  assign trial_w = shifted_w - {1'b0, den_r};
  assign fits_w = !trial_w[DIV_W];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rem_r <= '0;
      quo_r <= '0;
      den_r <= '0;
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start_i && !busy_r) begin
        rem_r <= '0;
        quo_r <= dividend_i;
        den_r <= divisor_i;
        cnt_r <= 7'(DIV_W);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        rem_r <= fits_w ? trial_w[DIV_W-1:0] : shifted_w[DIV_W-1:0];
        quo_r <= {quo_r[DIV_W-2:0], fits_w};
        cnt_r <= cnt_r - 7'h01;
        if (cnt_r == 7'h01) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign done_o = done_r;
  assign quotient_o = quo_r;

endmodule : sad_divider

// File: hw/speech_activity_spectral_front.sv
// per-frame speech activity front end with an AXI4-Lite register slave
//
// Functional notes
// - one speech flag per 20 ms frame
// - filtered energy from filter and frame autocorrelations
// - recent average sums last four frames
// - delayed average is recent average four frames back
// - solve normal equations; coefficient zero is -1
// - predictor uses the delayed average only
// - predictor autocorrelation from coefficient products
// - distortion from predictor and recent autocorrelations
// - absolute distortion change, then keep distortion
// - steady when distortion change below 0.05
// - speech when energy exceeds adaptive threshold
// - adapt only steady, unpitched, toneless frames
// - fixed low-level threshold also applied
// - hangover only after long enough bursts
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module speech_activity_spectral_front #(
  parameter int unsigned FRAME_CYCLES = sad_pkg::FRAME_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic frame_valid_i,
  input wire sad_pkg::frame_in_t frame_i,
  output logic busy_o,
  output logic frame_done_o,
  output sad_pkg::result_t result_o,
  input wire logic [sad_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [sad_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sad_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [sad_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sad_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_ENERGY, S_NORM, S_LD_ACC, S_LD_DIV, S_LD_UPD, S_RAV, S_DM_ACC, S_DM_DIV, S_DECIDE
  } state_t;

  function automatic logic signed [COEF_W-1:0] qmul(input logic signed [COEF_W-1:0] a,
                                                    input logic signed [COEF_W-1:0] b);
    logic signed [2*COEF_W-1:0] p;
    p = (2*COEF_W)'(a) * (2*COEF_W)'(b);
    return COEF_W'(p >>> COEF_FRAC);
  endfunction : qmul

  function automatic logic [ACC_W-1:0] mag(input logic signed [ACC_W-1:0] v);
    return v[ACC_W-1] ? ACC_W'(-v) : v;
  endfunction : mag

  function automatic logic [ADDR_W-1:0] word(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:2], 2'h0};
  endfunction : word

  // left shift that brings a positive value up under the sign bit
  function automatic logic [5:0] norm_shift(input logic [AV_W-1:0] v);
    logic [5:0] s;
    s = 6'(AV_W-2);
    for (int b = 0; b < AV_W-1; b++) begin
      if (v[b]) s = 6'(AV_W-2-b);
    end
    return s;
  endfunction : norm_shift

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  state_t state_r;
  logic signed [ACF_W-1:0] acf_r [NTAPS];
  logic signed [ACF_W-1:0] hist_r [FRAMES-1][NTAPS];
  logic signed [AV_W-1:0] av0_w [NTAPS];
  logic signed [AV_W-1:0] av0_r [NTAPS];
  logic signed [AV_W-1:0] av1_r [NTAPS];
  logic signed [AV_W-1:0] delay_r [FRAMES][NTAPS];
  logic pitch_r, tone_r;
  logic signed [RV_W-1:0] rvad_r [NTAPS];
  logic signed [COEF_W-1:0] a_r [NTAPS];
  logic signed [COEF_W-1:0] c_w [NTAPS];
  logic signed [R_W-1:0] r_r [NTAPS];
  logic signed [RAV_W-1:0] rav_r [NTAPS];
  logic signed [R_W-1:0] err_r, err_nxt;
  logic signed [COEF_W-1:0] k_r, ksq_w, upd_lo_w, upd_hi_w;
  logic [COEF_W-1:0] qsat_w;
  logic signed [ACC_W-1:0] acc_r, mul_x, mul_y, prod_w, term_w, acc_add_w, acc_raw_w, pv_w;
  logic [3:0] idx_r, j_r, ord_r;
  logic [5:0] sh_w;
  logic div_go_r, div_done, neg_r;
  logic [DIV_W-1:0] div_num_r, div_den_r, div_q;
  logic [PV_W-1:0] pvad_r;
  logic [TH_W-1:0] thvad_r, th_nxt, pfac_w, t_dec_w, t_inc_w, t_adp_w, pmarg_w;
  logic signed [DM_W-1:0] dm_r, lastdm_r;
  logic signed [DM_W:0] dm_diff_w;
  logic steady_w, quiet_w, low_w, fire_w, vvad_w, vad_w, start_w;
  logic [3:0] cnt_r, cnt_nxt;
  logic [2:0] burst_r, burst_inc_w, burst_nxt;
  logic signed [3:0] hang_r, hang_mid_w, hang_nxt;
  logic [CTRL_W-1:0] ctrl_r;
  logic frame_done_r;
  result_t result_r;
  logic [31:0] gap_r;
  logic [OVR_W-1:0] ovr_r;

  // a new frame is taken only when the previous one is finished
  assign start_w = frame_valid_i && (state_r == S_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // frame averaging
  // current frame plus three stored frames
  always_comb begin
    for (int i = 0; i < NTAPS; i++) begin
      av0_w[i] = AV_W'($signed(frame_i.acf[i]));
      for (int f = 0; f < FRAMES-1; f++) av0_w[i] = av0_w[i] + AV_W'(hist_r[f][i]);
    end
  end

  // capture encoder data; delay line of averaged vectors
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NTAPS; i++) begin
        acf_r[i] <= '0;
        av0_r[i] <= '0;
        av1_r[i] <= '0;
        for (int f = 0; f < FRAMES-1; f++) hist_r[f][i] <= '0;
        for (int d = 0; d < FRAMES; d++) delay_r[d][i] <= '0;
      end
      pitch_r <= 1'b0;
      tone_r <= 1'b0;
    end else if (start_w) begin
      for (int i = 0; i < NTAPS; i++) begin
        acf_r[i] <= $signed(frame_i.acf[i]);
        av0_r[i] <= av0_w[i];
        av1_r[i] <= delay_r[FRAMES-1][i];
        hist_r[0][i] <= $signed(frame_i.acf[i]);
        for (int f = 1; f < FRAMES-1; f++) hist_r[f][i] <= hist_r[f-1][i];
        delay_r[0][i] <= av0_w[i];
        for (int d = 1; d < FRAMES; d++) delay_r[d][i] <= delay_r[d-1][i];
      end
      pitch_r <= frame_i.pitch;
      tone_r <= frame_i.tone;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared multiplier and arithmetic helpers
  // coefficient zero is fixed at minus one
  always_comb begin
    c_w[0] = COEF_M1;
    for (int k = 1; k < NTAPS; k++) c_w[k] = a_r[k];
  end

  always_comb begin
    mul_x = '0;
    mul_y = '0;
    case (state_r)
      S_ENERGY: begin
        mul_x = ACC_W'(rvad_r[idx_r]);
        mul_y = ACC_W'(acf_r[idx_r]);
      end
      S_LD_ACC: begin
        mul_x = ACC_W'(a_r[j_r]);
        mul_y = ACC_W'(r_r[ord_r - j_r]);
      end
      S_RAV: begin
        mul_x = ACC_W'(c_w[j_r]);
        mul_y = ACC_W'(c_w[j_r + idx_r]);
      end
      S_DM_ACC: begin
        mul_x = ACC_W'(rav_r[idx_r]);
        mul_y = ACC_W'(av0_r[idx_r]);
      end
      default: ;
    endcase
  end

  // lag zero once, other lags twice
  assign prod_w = mul_x * mul_y;
  assign term_w = (idx_r == 4'h0) ? prod_w : (prod_w <<< 1);
  assign acc_add_w = acc_r + term_w;
  assign acc_raw_w = acc_r + prod_w;
  assign pv_w = acc_add_w >>> RVAD_FRAC;
  assign sh_w = norm_shift(av1_r[0]);
  assign qsat_w = (div_q >= DIV_W'(COEF_ONE)) ? COEF_W'(COEF_ONE - 1) : div_q[COEF_W-1:0];
  assign upd_lo_w = a_r[j_r] - qmul(k_r, a_r[ord_r - j_r]);
  assign upd_hi_w = a_r[ord_r - j_r] - qmul(k_r, a_r[j_r]);
  assign ksq_w = qmul(k_r, k_r);
  assign err_nxt = err_r - R_W'((ACC_W'(err_r) * ACC_W'(ksq_w)) >>> COEF_FRAC);

  sad_divider u_div (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .start_i(div_go_r),
    .dividend_i(div_num_r),
    .divisor_i(div_den_r),
    .done_o(div_done),
    .quotient_o(div_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decision logic for the frame in hand
  // absolute change against the previous distortion
  assign dm_diff_w = (DM_W+1)'(dm_r) - (DM_W+1)'(lastdm_r);
  // steady when the change is under the limit
  assign steady_w = (dm_diff_w[DM_W] ? -dm_diff_w : dm_diff_w) < (DM_W+1)'(STAT_THRESH_Q10);
  // adapt only with no speech cues present
  assign quiet_w = ctrl_r[CTRL_ADAPT_BIT] && steady_w && !pitch_r && !tone_r;
  // very low input forces the fixed level
  assign low_w = ctrl_r[CTRL_ADAPT_BIT] && (acf_r[0] < ACF_W'(PTH));
  assign cnt_nxt = low_w ? 4'h0 : (!quiet_w ? 4'h0 : ((cnt_r == 4'(ADP)) ? cnt_r : cnt_r + 4'h1));
  assign fire_w = !low_w && quiet_w && (cnt_nxt == 4'(ADP));
  assign pfac_w = TH_W'(pvad_r) * TH_W'(FAC);
  assign t_dec_w = thvad_r - (thvad_r >> DEC_SH);
  assign t_inc_w = thvad_r + (thvad_r >> INC_SH);
  assign t_adp_w = (t_dec_w >= pfac_w) ? t_dec_w : ((pfac_w < t_inc_w) ? pfac_w : t_inc_w);
  assign pmarg_w = TH_W'(pvad_r) + TH_W'(MARGIN);
  assign th_nxt = low_w ? TH_W'(PLEV) : (fire_w ? ((t_adp_w > pmarg_w) ? pmarg_w : t_adp_w)
                                                : thvad_r);
  // raw decision against the adapted threshold
  assign vvad_w = TH_W'(pvad_r) > th_nxt;
  // bursts of enough frames reload the hangover
  assign burst_inc_w = vvad_w ? burst_r + 3'h1 : 3'h0;
  assign burst_nxt = (burst_inc_w >= 3'(BURST_CONST)) ? 3'(BURST_CONST) : burst_inc_w;
  assign hang_mid_w = (burst_inc_w >= 3'(BURST_CONST)) ? 4'(HANG_CONST) : hang_r;
  assign hang_nxt = (hang_mid_w >= 0) ? hang_mid_w - 4'sh1 : hang_mid_w;
  assign vad_w = vvad_w || (ctrl_r[CTRL_HANG_BIT] && (hang_mid_w >= 0));

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= S_IDLE;
      acc_r <= '0;
      idx_r <= '0;
      j_r <= '0;
      ord_r <= '0;
      err_r <= '0;
      k_r <= '0;
      neg_r <= 1'b0;
      div_go_r <= 1'b0;
      div_num_r <= '0;
      div_den_r <= '0;
      pvad_r <= '0;
      dm_r <= '0;
      lastdm_r <= '0;
      thvad_r <= TH_W'(TH_INIT);
      cnt_r <= '0;
      burst_r <= '0;
      hang_r <= -4'sh1;
      result_r <= '0;
      frame_done_r <= 1'b0;
      for (int i = 0; i < NTAPS; i++) begin
        rvad_r[i] <= RVAD_INIT[i];
        a_r[i] <= '0;
        r_r[i] <= '0;
        rav_r[i] <= '0;
      end
    end else begin
      div_go_r <= 1'b0;
      frame_done_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (start_w) begin
            acc_r <= '0;
            idx_r <= '0;
            state_r <= S_ENERGY;
          end
        end
        S_ENERGY: begin
          if (idx_r == LAST_TAP) begin
            pvad_r <= pv_w[ACC_W-1] ? '0 : ((pv_w >= ACC_W'(1) <<< PV_W) ? '1 : PV_W'(pv_w));
            state_r <= S_NORM;
          end else begin
            acc_r <= acc_add_w;
            idx_r <= idx_r + 4'h1;
          end
        end
        S_NORM: begin
          for (int i = 0; i < NTAPS; i++) begin
            a_r[i] <= '0;
            r_r[i] <= R_W'((av1_r[i] <<< sh_w) >>> (AV_W - R_W));
          end
          ord_r <= 4'h1;
          j_r <= 4'h0;
          idx_r <= 4'h0;
          acc_r <= '0;
          state_r <= (av1_r[0] > 0) ? S_LD_ACC : S_RAV;
        end
        S_LD_ACC: begin
          if (j_r == 4'h0) begin
            acc_r <= ACC_W'(r_r[ord_r]) <<< COEF_FRAC;
            if (ord_r == 4'h1) err_r <= r_r[0];
            j_r <= 4'h1;
          end else if (j_r < ord_r) begin
            acc_r <= acc_r - prod_w;
            j_r <= j_r + 4'h1;
          end else begin
            div_go_r <= 1'b1;
            div_num_r <= mag(acc_r);
            div_den_r <= DIV_W'(err_r);
            neg_r <= acc_r[ACC_W-1];
            state_r <= S_LD_DIV;
          end
        end
        S_LD_DIV: begin
          if (div_done) begin
            k_r <= neg_r ? -$signed(qsat_w) : $signed(qsat_w);
            j_r <= 4'h1;
            state_r <= S_LD_UPD;
          end
        end
        S_LD_UPD: begin
          if (j_r <= (ord_r >> 1)) begin
            a_r[j_r] <= upd_lo_w;
            if (j_r != ord_r - j_r) a_r[ord_r - j_r] <= upd_hi_w;
            j_r <= j_r + 4'h1;
          end else begin
            a_r[ord_r] <= k_r;
            acc_r <= '0; // lag sums below must not inherit the last solver residue
            err_r <= (err_nxt < 1) ? R_W'(1) : err_nxt;
            j_r <= 4'h0;
            ord_r <= ord_r + 4'h1;
            state_r <= (ord_r == LAST_TAP) ? S_RAV : S_LD_ACC;
          end
        end
        // lag idx_r sum of coefficient products
        S_RAV: begin
          if (j_r == LAST_TAP - idx_r) begin
            rav_r[idx_r] <= RAV_W'(acc_raw_w >>> (2*COEF_FRAC - RVAD_FRAC));
            acc_r <= '0;
            j_r <= 4'h0;
            idx_r <= (idx_r == LAST_TAP) ? 4'h0 : idx_r + 4'h1;
            if (idx_r == LAST_TAP) state_r <= S_DM_ACC;
          end else begin
            acc_r <= acc_raw_w;
            j_r <= j_r + 4'h1;
          end
        end
        // weighted products, then divide by lag zero
        S_DM_ACC: begin
          if (idx_r == LAST_TAP) begin
            div_go_r <= (av0_r[0] > 0);
            div_num_r <= mag(acc_add_w);
            div_den_r <= DIV_W'(av0_r[0]);
            neg_r <= acc_add_w[ACC_W-1];
            if (av0_r[0] <= 0) dm_r <= '0;
            state_r <= (av0_r[0] > 0) ? S_DM_DIV : S_DECIDE;
          end else begin
            acc_r <= acc_add_w;
            idx_r <= idx_r + 4'h1;
          end
        end
        S_DM_DIV: begin
          if (div_done) begin
            dm_r <= neg_r ? -$signed(DM_W'(div_q)) : $signed(DM_W'(div_q));
            state_r <= S_DECIDE;
          end
        end
        S_DECIDE: begin
          lastdm_r <= dm_r;
          thvad_r <= th_nxt;
          cnt_r <= cnt_nxt;
          burst_r <= burst_nxt;
          hang_r <= hang_nxt;
          result_r <= '{speech: vad_w, raw_speech: vvad_w, steady: steady_w};
          frame_done_r <= 1'b1;
          // filter follows the predictor on quiet frames once ADP of them have run in a row
          if (fire_w) begin
            for (int i = 0; i < NTAPS; i++) rvad_r[i] <= RV_W'(rav_r[i]);
          end
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame spacing watch and refused-strobe count
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gap_r <= '0;
      ovr_r <= '0;
    end else begin
      gap_r <= start_w ? '0 : ((gap_r < FRAME_CYCLES) ? gap_r + 32'h1 : gap_r);
      if (frame_valid_i && !start_w && (ovr_r != '1)) ovr_r <= ovr_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic wr_go_w, wr_hit_w, rd_go_w, bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r, rresp_w;
  logic [DATA_W-1:0] rdata_r, rdata_w;

  assign wr_go_w = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign s_axi_awready = wr_go_w;
  assign s_axi_wready = wr_go_w;
  assign wr_hit_w = (word(s_axi_awaddr) == ADDR_CTRL);
  assign rd_go_w = s_axi_arvalid && !rvalid_r;
  assign s_axi_arready = !rvalid_r;

  // read decode
  always_comb begin
    rdata_w = '0;
    rresp_w = RESP_OKAY;
    if (word(s_axi_araddr) == ADDR_CTRL) begin
      rdata_w[CTRL_W-1:0] = ctrl_r;
    end else if (word(s_axi_araddr) == ADDR_STATUS) begin
      rdata_w[ST_SPEECH_BIT] = result_r.speech;
      rdata_w[ST_RAW_BIT] = result_r.raw_speech;
      rdata_w[ST_STEADY_BIT] = result_r.steady;
      rdata_w[ST_BUSY_BIT] = (state_r != S_IDLE);
      rdata_w[ST_OVERDUE_BIT] = (gap_r >= FRAME_CYCLES);
      rdata_w[ST_OVR_LSB +: OVR_W] = ovr_r;
    end else if (word(s_axi_araddr) == ADDR_THRESH) begin
      rdata_w = thvad_r[DATA_W-1:0];
    end else if (word(s_axi_araddr) == ADDR_ENERGY) begin
      rdata_w = pvad_r[DATA_W-1:0];
    end else if (word(s_axi_araddr) == ADDR_DIST) begin
      rdata_w = dm_r[DATA_W-1:0];
    end else begin
      rresp_w = RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_r <= CTRL_RESET;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end else begin
      if (wr_go_w) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit_w ? RESP_OKAY : RESP_SLVERR;
        if (wr_hit_w && s_axi_wstrb[0]) ctrl_r <= s_axi_wdata[CTRL_W-1:0];
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (rd_go_w) begin
        rvalid_r <= 1'b1;
        rdata_r <= rdata_w;
        rresp_r <= rresp_w;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign busy_o = (state_r != S_IDLE);
  assign frame_done_o = frame_done_r;
  assign result_o = result_r;

endmodule : speech_activity_spectral_front

// File: testbench/sad_props.sv
// concurrent checks on the frame handshake and the decision outputs
`timescale 1ns/100ps
module sad_props (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic frame_valid_i,
  input wire logic busy_o,
  input wire logic frame_done_o,
  input wire sad_pkg::result_t result_o
);
  import sad_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////
  // frame handshake and completion timing
  a_take_busy: assert property (frame_valid_i && !busy_o |=> busy_o)
    else $error("strobe taken while idle did not start work");
  a_busy_cause: assert property ($rose(busy_o) |-> $past(frame_valid_i))
    else $error("work started without a strobe");
  a_done_bound: assert property ($rose(busy_o) |-> ##[1:1000] frame_done_o)
    else $error("frame not finished in time");
  a_busy_hold: assert property (busy_o && !frame_done_o |=> busy_o || frame_done_o)
    else $error("busy dropped before completion");
  a_done_busy: assert property (frame_done_o |-> $fell(busy_o))
    else $error("completion outside a frame");
  a_done_pulse: assert property (frame_done_o |=> !frame_done_o && (busy_o == $past(frame_valid_i)))
    else $error("completion not a single pulse");
  ////////////////////////////////////////
  // decision outputs
  a_result_hold: assert property (!frame_done_o |-> $stable(result_o))
    else $error("decision changed between frames");
  a_raw_final: assert property (result_o.raw_speech |-> result_o.speech)
    else $error("raw speech not in final flag");
  c_steady: cover property (frame_done_o && result_o.steady);
  c_hang: cover property (frame_done_o && result_o.speech && !result_o.raw_speech);
  c_refused: cover property (frame_valid_i && busy_o);
endmodule : sad_props
bind speech_activity_spectral_front sad_props u_props (.*);

// File: testbench/sad_encoder_model.sv
// encoder stand-in that hands one frame of autocorrelations per strobe
`timescale 1ns/100ps
module sad_encoder_model (
  input wire logic clk_i,
  output logic frame_valid_o,
  output sad_pkg::frame_in_t frame_o
);
  import sad_pkg::*;
  // idle at time zero
  initial begin
    frame_valid_o = 1'b0;
    frame_o = '0;
  end
  // acf halves per lag, as from 16-bit samples
  task automatic send(input logic [ACF_W-1:0] a, input logic p);
    frame_in_t f;
    f.pitch = p;
    f.tone = p;
    for (int i = 0; i < NTAPS; i++) f.acf[i] = a >> i;
    frame_valid_o <= 1'b1;
    frame_o <= f;
    @(posedge clk_i);
    frame_valid_o <= 1'b0;
    frame_o <= ~f; // stale frame not left on the lines
  endtask : send
endmodule : sad_encoder_model

// File: testbench/tb.sv
// self-checking bench for the speech activity front end
`timescale 1ns/100ps
module tb;
  import sad_pkg::*;
  localparam logic [31:0] LOUD = 32'h0100_0000;
  localparam logic [31:0] QUIET = 32'h0001_0000;
  logic clk_i, srst_i, frame_valid_i, busy_o, frame_done_o;
  frame_in_t frame_i;
  result_t result_o;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int errors = 0;
  int compares = 0;
  speech_activity_spectral_front #(.FRAME_CYCLES(2000)) dut (.*);
  sad_encoder_model enc (.clk_i, .frame_valid_o(frame_valid_i), .frame_o(frame_i));
  ////////////////////////////////////////
  // clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #300000;
    errors++;
    complete_run();
  end
  ////////////////////////////////////////
  // compare, verdict and bus tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic complete_run;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_i); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata & m, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge clk_i); while ((s_axi_awready & s_axi_wready) !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge clk_i); while (s_axi_bvalid !== 1'b1);
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr
  // one frame, then its decision under a mask
  task automatic frm(input logic [31:0] a, input logic p, input logic [2:0] m, e);
    enc.send(a, p);
    do @(posedge clk_i); while (frame_done_o !== 1'b1);
    chk(32'(result_o & m), 32'(e));
  endtask : frm
  ////////////////////////////////////////
  // main sequence
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    srst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(ADDR_CTRL, '1, 32'h3, RESP_OKAY);
    for (int k = 0; k < 8; k++) frm(LOUD, 1'b1, 3'h7, {2'b11, 1'(k % 4 != 0)});
    rd(ADDR_ENERGY, '1, 32'h0280_0000, RESP_OKAY);
    for (int k = 0; k < 6; k++) frm(QUIET, 1'b0, 3'h6, {1'(k < 5), 2'b00});
    rd(ADDR_THRESH, '1, 32'h000c_3500, RESP_OKAY);
    enc.send(LOUD, 1'b1);
    @(posedge clk_i);
    frm(LOUD, 1'b1, 3'h6, 3'h6);
    frm(LOUD, 1'b1, 3'h6, 3'h6);
    frm(QUIET, 1'b1, 3'h6, 3'h0);
    rd(ADDR_STATUS, 32'h0000_ff18, 32'h0000_0100, RESP_OKAY);
    rd(8'h20, '1, '0, RESP_SLVERR);
    wr(ADDR_THRESH, 32'h1, RESP_SLVERR);
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    rd(ADDR_CTRL, '1, 32'h1, RESP_OKAY);
    // hangover off: a full burst, then a quiet frame drops speech at once
    for (int k = 0; k < 3; k++) frm(LOUD, 1'b1, 3'h6, 3'h6);
    frm(QUIET, 1'b1, 3'h6, 3'h0);
    repeat (2100) @(posedge clk_i);
    rd(ADDR_STATUS, 32'h10, 32'h10, RESP_OKAY);
    complete_run();
  end
endmodule : tb
